// [cts_timing_status.sv]
//Function
// - loopback feeds transmitter to receiver, pin recessive
// - loopback treats own frame received, ignores ack
// - wake filter needs long dominant, else edge
// - clock source picks pll or crystal half
// - timing registers writable only in soft reset
// - jump width is field plus one quanta
// - prescaler field plus one divides module clock
// - triple sampling takes majority of three
// - segment one is field plus one quanta
// - segment two is field plus one quanta
// - bit time is prescale times total quanta
// - flags clear by writing one, condition gone
// - bus activity in sleep sets wake flag
// - receive warning above 96 when not passive
// - transmit warning above 96 when not passive
// - receive passive above 127 unless bus off
// - transmit passive 128 to 255 unless bus off
// - bus off above 255, holds 128 recessive runs
// - overrun event sets overrun flag
// - receive full blocks swap until cleared
// - enables gate flags onto three interrupts
// - soft reset holds flags and enables cleared
`timescale 1ns/1ns
`include "cts_consts.svh"
module cts_timing_status
  import cts_pkg::*;
#(
  parameter int WAKE_CYCLES = `CTS_WAKE_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output cts_byte_t       reg_rdata,
  // controller core side
  input  wire logic       soft_reset_bit,
  input  wire logic       sleep_mode,
  input  wire logic [7:0] receive_error_count,
  input  wire logic [8:0] transmit_error_count,
  input  wire logic       recessive_run_done,
  input  wire logic       overrun_event,
  input  wire logic       swap_request,
  input  wire logic       tx_bit_stream,
  // module clock enables
  input  wire logic       pll_system_clock,
  input  wire logic       crystal_clock,
  // bus pins
  input  wire logic       bus_receive_pin,
  output logic            bus_transmit_pin,
  // bit stream and timing to the core
  output logic            receiver_bit,
  output logic            sample_strobe,
  output logic            sampled_bit,
  output logic            bit_start,
  output logic            ack_check_off,
  output logic            swap_grant,
  // interrupts
  output logic            wake_irq,
  output logic            error_irq,
  output logic            receive_irq
);
  ////////////////////////////////////////////////////////////////////////
  // registers and decode
  cts_byte_t  module_control_two;      // loopback, filter, clock source
  cts_byte_t  bit_timing_zero;         // jump width, prescaler
  cts_byte_t  bit_timing_one;          // sampling, segments
  cts_byte_t  receiver_event_flags;    // sticky status
  cts_byte_t  receiver_event_enables;  // interrupt gates
  cts_byte_t  set_vec;                 // flag set terms
  cts_byte_t  cond_vec;                // setting conditions still true
  cts_byte_t  clr_vec;                 // write one to clear
  logic       cfg_write;               // config write allowed
  logic       loopback_enable;         // internal loop
  logic       wake_filter_select;      // filtered wakeup
  logic       clock_source_select;     // pll versus crystal half
  logic [1:0] resync_jump_width;       // field
  logic [5:0] quantum_prescaler;       // field
  logic       triple_sample_enable;    // majority voting
  logic [3:0] first_segment_length;    // field
  logic [2:0] second_segment_length;   // field

  assign loopback_enable       = module_control_two[`CTS_LOOPBACK_ENABLE_BIT];
  assign wake_filter_select    = module_control_two[`CTS_WFILT_BIT];
  assign clock_source_select   = module_control_two[`CTS_CLOCK_SOURCE_SELECT_BIT];
  assign resync_jump_width     = bit_timing_zero[`CTS_SJW_LSB +: 2];
  assign quantum_prescaler     = bit_timing_zero[5:0];
  assign triple_sample_enable  = bit_timing_one[`CTS_TRIPLE_SAMPLE_ENABLE_BIT];
  assign second_segment_length = bit_timing_one[`CTS_SECOND_SEGMENT_LENGTH_LSB +: 3];
  assign first_segment_length  = bit_timing_one[3:0];
  assign cfg_write             = reg_write & soft_reset_bit;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers, writable in soft reset only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      module_control_two <= `CTS_CTL2_RESET;
      bit_timing_zero    <= `CTS_BT0_RESET;
      bit_timing_one     <= `CTS_BT1_RESET;
    end else if (cfg_write) begin
      // upper bits of control two are unimplemented
      if (reg_addr == `CTS_OFF_CTL2)
        module_control_two <= {5'h00, reg_wdata[2:0]};
      if (reg_addr == `CTS_OFF_BT0)
        bit_timing_zero <= reg_wdata;
      if (reg_addr == `CTS_OFF_BT1)
        bit_timing_one <= reg_wdata;
    end
  end

  // interrupt enables, held cleared in soft reset
  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset_bit) begin
      receiver_event_enables <= `CTS_ENABLES_RESET;
    end else if (reg_write && reg_addr == `CTS_OFF_ENABLES) begin
      receiver_event_enables <= reg_wdata;
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n || !reg_read) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `CTS_OFF_CTL2:    reg_rdata <= module_control_two;
        `CTS_OFF_BT0:     reg_rdata <= bit_timing_zero;
        `CTS_OFF_BT1:     reg_rdata <= bit_timing_one;
        `CTS_OFF_FLAGS:   reg_rdata <= receiver_event_flags;
        `CTS_OFF_ENABLES: reg_rdata <= receiver_event_enables;
        default:          reg_rdata <= 8'h00; // unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and loopback path
  logic rx_meta;   // first stage
  logic rx_sync;   // second stage

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= bus_receive_pin;
      rx_sync <= rx_meta;
    end
  end

  // loop routes transmitter inward and parks the pin recessive
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      receiver_bit     <= 1'b1;
      bus_transmit_pin <= 1'b1;
      ack_check_off    <= 1'b0;
    end else begin
      receiver_bit     <= loopback_enable ? tx_bit_stream : rx_sync;
      bus_transmit_pin <= loopback_enable | tx_bit_stream;
      ack_check_off    <= loopback_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wakeup detection
  logic        rx_prev;   // last synced level
  logic [15:0] dom_cnt;   // dominant length in cycles
  logic        wake_evt;  // bus activity while asleep

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_prev <= 1'b1;
      dom_cnt <= 16'h0000;
    end else begin
      rx_prev <= rx_sync;
      if (rx_sync)
        dom_cnt <= 16'h0000;
      else if (dom_cnt != 16'hffff)
        dom_cnt <= dom_cnt + 16'h0001;
    end
  end

  // filtered: dominant held long enough; else any falling edge
  assign wake_evt = sleep_mode & (wake_filter_select ?
    (!rx_sync && dom_cnt == 16'(WAKE_CYCLES - 1)) :
    (rx_prev && !rx_sync));

  ////////////////////////////////////////////////////////////////////////
  // receiver flags
  logic [7:0] boff_runs;   // recessive runs seen while bus off
  logic       boff_hold;   // bus off condition still true
  logic       rx_warn;     // receive count above warning
  logic       tx_warn;     // transmit count above warning
  logic       no_passive;  // no passive nor bus off flag

  assign no_passive = ~receiver_event_flags[`CTS_RERR_BIT] &
                      ~receiver_event_flags[`CTS_TERR_BIT] &
                      ~receiver_event_flags[`CTS_BOFF_BIT];
  assign rx_warn = receive_error_count > `CTS_WARN_LIMIT;
  assign tx_warn = transmit_error_count > {1'b0, `CTS_WARN_LIMIT};
  assign boff_hold = (transmit_error_count > `CTS_TX_MAX) |
    (receiver_event_flags[`CTS_BOFF_BIT] &
     (boff_runs < `CTS_RECESSIVE_RUNS));

  // set terms per flag
  always_comb begin
    set_vec = 8'h00;
    set_vec[`CTS_WAKE_BIT] = wake_evt;
    set_vec[`CTS_RWRN_BIT] = rx_warn & no_passive;
    set_vec[`CTS_TWRN_BIT] = tx_warn & no_passive;
    set_vec[`CTS_RERR_BIT] = (receive_error_count > `CTS_RX_PASS_LIMIT) &
                             ~receiver_event_flags[`CTS_BOFF_BIT];
    set_vec[`CTS_TERR_BIT] = (transmit_error_count >= `CTS_TX_PASS_MIN) &
                             (transmit_error_count <= `CTS_TX_MAX) &
                             ~receiver_event_flags[`CTS_BOFF_BIT];
    set_vec[`CTS_BOFF_BIT] = transmit_error_count > `CTS_TX_MAX;
    set_vec[`CTS_OVR_BIT]  = overrun_event;
    set_vec[`CTS_RXF_BIT]  = swap_request &
                             ~receiver_event_flags[`CTS_RXF_BIT];
    cond_vec = set_vec;
    cond_vec[`CTS_BOFF_BIT] = boff_hold;
  end

  assign clr_vec = (reg_write && reg_addr == `CTS_OFF_FLAGS) ?
                   reg_wdata : 8'h00;

  // set wins; clear only where the condition is gone
  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset_bit) begin
      receiver_event_flags <= `CTS_FLAGS_RESET;
    end else begin
      receiver_event_flags <= set_vec |
        (receiver_event_flags & ~(clr_vec & ~cond_vec));
    end
  end

  // count recessive runs while bus off
  always_ff @(posedge clk) begin
    if (!reset_n || !receiver_event_flags[`CTS_BOFF_BIT]) begin
      boff_runs <= 8'h00;
    end else if (recessive_run_done &&
                 boff_runs < `CTS_RECESSIVE_RUNS) begin
      boff_runs <= boff_runs + 8'h01;
    end
  end

  // swap handshake and interrupt lines
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      swap_grant  <= 1'b0;
      wake_irq    <= 1'b0;
      error_irq   <= 1'b0;
      receive_irq <= 1'b0;
    end else begin
      swap_grant  <= set_vec[`CTS_RXF_BIT] & ~soft_reset_bit;
      wake_irq    <= receiver_event_flags[7] &
                     receiver_event_enables[7];
      error_irq   <= |(receiver_event_flags[6:1] &
                       receiver_event_enables[6:1]);
      // own looped frame lands here too
      receive_irq <= receiver_event_flags[0] &
                     receiver_event_enables[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // module clock enable and quantum prescaler
  logic       xtal_half;  // crystal divided by two
  logic       mclk_en;    // module clock tick
  logic [5:0] presc_cnt;  // prescaler position
  logic       tq_tick;    // one quantum elapsed

  assign mclk_en = clock_source_select ? pll_system_clock :
                   (crystal_clock & xtal_half);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      xtal_half <= 1'b0;
    end else if (crystal_clock) begin
      xtal_half <= ~xtal_half;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset_bit) begin
      presc_cnt <= 6'h00;
      tq_tick   <= 1'b0;
    end else begin
      tq_tick <= mclk_en && presc_cnt == quantum_prescaler;
      if (mclk_en)
        presc_cnt <= (presc_cnt == quantum_prescaler) ? 6'h00 :
                     presc_cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit timing state machine
  cts_phase_t phase;     // current segment
  logic [4:0] seg_cnt;   // quanta left in segment
  logic [4:0] elapsed;   // quanta since sync
  logic       resynced;  // one resync per bit
  logic [2:0] hist;      // quantum samples
  logic       edge_seen; // recessive to dominant
  logic       do_resync; // edge acted upon
  logic [4:0] sjw_q;     // jump width in quanta
  logic [4:0] grow;      // lengthening amount
  logic       short_new; // edge close to bit end
  logic       vote;      // majority of three

  assign sjw_q     = {3'h0, resync_jump_width} + 5'h01;
  assign grow      = (elapsed + 5'h01 < sjw_q) ? elapsed + 5'h01 : sjw_q;
  assign edge_seen = hist[0] & ~receiver_bit;
  assign do_resync = tq_tick & edge_seen & ~resynced &
                     (phase != phase_sync);
  assign short_new = seg_cnt < sjw_q;
  assign vote = (receiver_bit & hist[0]) | (receiver_bit & hist[1]) |
                (hist[0] & hist[1]);

  // sample history per quantum
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hist <= 3'h7;
    end else if (tq_tick) begin
      hist <= {hist[1:0], receiver_bit};
    end
  end

  // sync, first segment, second segment per bit
  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset_bit) begin
      phase    <= phase_sync;
      seg_cnt  <= 5'h00;
      elapsed  <= 5'h00;
      resynced <= 1'b0;
    end else if (tq_tick) begin
      unique case (phase)
        phase_sync: begin
          phase    <= first_phase_segment;
          seg_cnt  <= {1'b0, first_segment_length};
          elapsed  <= 5'h00;
          resynced <= 1'b0;
        end
        first_phase_segment: begin
          if (do_resync) begin
            seg_cnt  <= seg_cnt + grow;
            resynced <= 1'b1;
          end else if (seg_cnt == 5'h00) begin
            phase   <= phase_seg2;
            seg_cnt <= {2'h0, second_segment_length};
          end else begin
            seg_cnt <= seg_cnt - 5'h01;
            elapsed <= elapsed + 5'h01;
          end
        end
        phase_seg2: begin
          if (do_resync && short_new) begin
            // edge quantum becomes the next sync
            phase    <= first_phase_segment;
            seg_cnt  <= {1'b0, first_segment_length};
            elapsed  <= 5'h00;
            resynced <= 1'b0;
          end else if (do_resync) begin
            seg_cnt  <= seg_cnt - sjw_q;
            resynced <= 1'b1;
          end else if (seg_cnt == 5'h00) begin
            phase <= phase_sync;
          end else begin
            seg_cnt <= seg_cnt - 5'h01;
          end
        end
      endcase
    end
  end

  // sample point and bit boundary outputs
  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset_bit) begin
      sample_strobe <= 1'b0;
      sampled_bit   <= 1'b1;
      bit_start     <= 1'b0;
    end else begin
      sample_strobe <= tq_tick && phase == first_phase_segment &&
                       seg_cnt == 5'h00 && !do_resync;
      if (tq_tick && phase == first_phase_segment && seg_cnt == 5'h00 &&
          !do_resync)
        sampled_bit <= triple_sample_enable ? vote : receiver_bit;
      bit_start <= tq_tick && ((phase == phase_seg2 && seg_cnt == 5'h00 &&
                   !do_resync) || (phase == phase_seg2 && do_resync &&
                   short_new));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  cfg_locked_a: assert property (
    reg_write && !soft_reset_bit |=> $stable(bit_timing_one) &&
    $stable(module_control_two) && $stable(bit_timing_zero))
    else $error("config changed outside soft reset");
  loop_pin_a: assert property (
    loopback_enable |=> bus_transmit_pin && receiver_bit ==
    $past(tx_bit_stream))
    else $error("loopback path wrong");
  soft_hold_a: assert property (
    soft_reset_bit |=> receiver_event_flags == 8'h00 &&
    receiver_event_enables == 8'h00)
    else $error("flags not held in soft reset");
  boff_stay_a: assert property (
    !soft_reset_bit && receiver_event_flags[2] && boff_runs < 8'd128
    && !$past(soft_reset_bit) |=> receiver_event_flags[2] || soft_reset_bit)
    else $error("bus off cleared early");
  rx_warn_a: assert property (
    !soft_reset_bit && receive_error_count > 8'd96 && no_passive
    ##1 !soft_reset_bit |-> receiver_event_flags[6])
    else $error("receive warning missed");
  swap_block_a: assert property (
    receiver_event_flags[0] |=> !swap_grant)
    else $error("swap granted while full");
  err_irq_a: assert property (
    receiver_event_flags[1] && receiver_event_enables[1] |=> error_irq)
    else $error("overrun interrupt missing");
  wake_irq_a: assert property (
    !receiver_event_flags[7] || !receiver_event_enables[7] |=> !wake_irq)
    else $error("spurious wake interrupt");
  tq_space_a: assert property (
    tq_tick && quantum_prescaler != 6'h00 |=> !tq_tick)
    else $error("quantum ticks too close");
  clr_set_a: assert property (
    !soft_reset_bit && overrun_event ##1 !soft_reset_bit
    |-> receiver_event_flags[1])
    else $error("overrun event lost");

  loop_cov: cover property (loopback_enable && sample_strobe);
  wake_cov: cover property (sleep_mode && wake_evt && wake_filter_select);
  resync_cov: cover property (do_resync && short_new);
  boff_cov: cover property (receiver_event_flags[2] ##1
                            !receiver_event_flags[2]);
endmodule

// [cts_consts.svh]
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH
// register offsets
`define CTS_OFF_CTL2       4'h1
`define CTS_OFF_BT0        4'h2
`define CTS_OFF_BT1        4'h3
`define CTS_OFF_FLAGS      4'h4
`define CTS_OFF_ENABLES    4'h5
// reset values
`define CTS_CTL2_RESET     8'h00
`define CTS_BT0_RESET      8'h00
`define CTS_BT1_RESET      8'h00
`define CTS_FLAGS_RESET    8'h00
`define CTS_ENABLES_RESET  8'h00
// control two bits
`define CTS_LOOPBACK_ENABLE_BIT      2
`define CTS_WFILT_BIT      1
`define CTS_CLOCK_SOURCE_SELECT_BIT     0
// bit timing fields
`define CTS_SJW_LSB        6
`define CTS_TRIPLE_SAMPLE_ENABLE_BIT       7
`define CTS_SECOND_SEGMENT_LENGTH_LSB      4
// flag and enable bit positions
`define CTS_WAKE_BIT       7
`define CTS_RWRN_BIT       6
`define CTS_TWRN_BIT       5
`define CTS_RERR_BIT       4
`define CTS_TERR_BIT       3
`define CTS_BOFF_BIT       2
`define CTS_OVR_BIT        1
`define CTS_RXF_BIT        0
// error count limits
`define CTS_WARN_LIMIT     8'd96
`define CTS_RX_PASS_LIMIT  8'd127
`define CTS_TX_PASS_MIN    9'd128
`define CTS_TX_MAX         9'd255
`define CTS_RECESSIVE_RUNS 8'd128
// wake filter time
`define CTS_CLK_NS         8
`define CTS_WAKE_NS        2000
`define CTS_WAKE_CYCLES    ((`CTS_WAKE_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
`endif

// [cts_pkg.sv]
package cts_pkg;
  // bit time phases, one-hot
  typedef enum logic [2:0] {
    phase_sync = 3'h1,
    first_phase_segment = 3'h2,
    phase_seg2 = 3'h4
  } cts_phase_t;
  typedef logic [7:0] cts_byte_t;
endpackage

// [cts_bus_node.sv]
`timescale 1ns/1ns
// far-side node: bus has a pull-up, so a released line reads recessive
module cts_bus_node (
  // clock
  input  wire logic clk,
  // bus wire
  input  wire logic bus_transmit_pin,
  output logic      bus_line
);
  logic pull_low; // node drives dominant
  initial pull_low = 1'b0;
  // wired-and of our pin and the node
  assign bus_line = bus_transmit_pin & ~pull_low;
  // hold dominant for n cycles, changed right after rising edges
  task automatic dominant(input int n);
    @(posedge clk);
    pull_low <= 1'b1;
    repeat (n) @(posedge clk);
    pull_low <= 1'b0;
  endtask
endmodule

// [tb.sv]
`timescale 1ns/1ns
`include "cts_consts.svh"
module tb;
  import cts_pkg::*;
  logic       clk, reset_n, reg_write, reg_read, soft_reset_bit;
  logic       sleep_mode, recessive_run_done, overrun_event;
  logic       swap_request, tx_bit_stream, pll_system_clock;
  logic       crystal_clock, bus_receive_pin, bus_transmit_pin;
  logic       receiver_bit, sample_strobe, sampled_bit, bit_start;
  logic       ack_check_off, swap_grant, wake_irq, error_irq;
  logic       receive_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, receive_error_count;
  logic [8:0] transmit_error_count;
  cts_byte_t  reg_rdata;
  int         error_cnt, check_count;
  cts_timing_status #(.WAKE_CYCLES(4)) cts_timing_status_i (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .soft_reset_bit, .sleep_mode, .receive_error_count,
    .transmit_error_count, .recessive_run_done, .overrun_event,
    .swap_request, .tx_bit_stream, .pll_system_clock, .crystal_clock,
    .bus_receive_pin, .bus_transmit_pin, .receiver_bit, .sample_strobe,
    .sampled_bit, .bit_start, .ack_check_off, .swap_grant, .wake_irq,
    .error_irq, .receive_irq);
  cts_bus_node cts_bus_node_i (.clk, .bus_transmit_pin,
    .bus_line(bus_receive_pin));
  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // compare seen against expected
  task automatic check(string n, logic [8:0] seen, logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(logic [3:0] a, cts_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // read, data taken in the cycle after the strobe, masked compare
  task automatic rdc(string n, logic [3:0] a, cts_byte_t m, cts_byte_t e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(n, reg_rdata & m, e);
  endtask
  // configure inside soft reset, then leave it
  task automatic cfg(cts_byte_t c2, cts_byte_t b0, cts_byte_t b1);
    @(posedge clk);
    soft_reset_bit <= 1'b1;
    wr(`CTS_OFF_CTL2, c2);
    wr(`CTS_OFF_BT0, b0);
    wr(`CTS_OFF_BT1, b1);
    @(posedge clk);
    soft_reset_bit <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  // reset values and unmapped places
  task automatic t_reset;
    for (int a = 0; a < 16; a++)
      rdc("reset", 4'(a), 8'hff, 8'h00);
  endtask
  // config writes refused outside soft reset
  task automatic t_gate;
    wr(`CTS_OFF_CTL2, 8'hff);
    rdc("ctl2 gated", `CTS_OFF_CTL2, 8'hff, 8'h00);
    cfg(8'hff, 8'ha5, 8'h3c);
    rdc("ctl2", `CTS_OFF_CTL2, 8'hff, 8'h07);
    rdc("bt0", `CTS_OFF_BT0, 8'hff, 8'ha5);
    wr(`CTS_OFF_BT1, 8'h00);
    rdc("bt1 gated", `CTS_OFF_BT1, 8'hff, 8'h3c);
  endtask
  // loop-back routes transmitter inward, pin recessive
  task automatic t_loop;
    cfg(8'h05, 8'h00, 8'h23);
    @(posedge clk);
    tx_bit_stream <= 1'b0;
    cyc(4);
    check("tx pin", bus_transmit_pin, 1'b1);
    check("rx bit", receiver_bit, 1'b0);
    check("ack off", ack_check_off, 1'b1);
    @(posedge clk);
    tx_bit_stream <= 1'b1;
    fork
      cts_bus_node_i.dominant(8);
      begin cyc(6); check("pin ignored", receiver_bit, 1'b1); end
    join
    cfg(8'h01, 8'h00, 8'h23);
    tx_bit_stream <= 1'b0;
    cyc(6);
    check("normal rx", receiver_bit, 1'b0);
    check("ack on", ack_check_off, 1'b0);
    @(posedge clk);
    tx_bit_stream <= 1'b1;
  endtask
  // cycles between two bit starts
  task automatic next_start(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (bit_start !== 1'b1 && n < 400);
  endtask
  task automatic measure(cts_byte_t c2, cts_byte_t b0, cts_byte_t b1);
    int n, e;
    cfg(c2, b0, b1);
    e = (b0[5:0] + 1) * (3 + b1[3:0] + b1[6:4]) * (c2[0] ? 1 : 2);
    next_start(n);
    next_start(n);
    check("bit time", 9'(n), 9'(e));
  endtask
  task automatic t_time;
    measure(8'h01, 8'h01, 8'h23);
    measure(8'h00, 8'h01, 8'h23);
    measure(8'h01, 8'h00, 8'h7f);
  endtask
  // release one quantum before the sample point: vote keeps dominant
  task automatic t_triple_sample_enable;
    int n;
    for (int f = 0; f < 2; f++) begin
      cfg(8'h05, 8'h00, f ? 8'ha3 : 8'h23);
      tx_bit_stream <= 1'b0;
      cyc(30);
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (sample_strobe !== 1'b1 && n < 20);
      check("dominant", sampled_bit, 1'b0);
      repeat (6) @(posedge clk);
      tx_bit_stream <= 1'b1;
      cyc(2);
      check("strobe", sample_strobe, 1'b1);
      check("vote", sampled_bit, f ? 1'b0 : 1'b1);
    end
  endtask
  // overrun flag, enable gating, clear, soft reset hold
  task automatic t_flags;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      overrun_event <= 1'b1;
      @(posedge clk);
      overrun_event <= 1'b0;
    end
    cyc(2);
    check("irq masked", error_irq, 1'b0);
    rdc("ovr set", `CTS_OFF_FLAGS, 8'h02, 8'h02);
    wr(`CTS_OFF_ENABLES, 8'h02);
    cyc(2);
    check("irq on", error_irq, 1'b1);
    wr(`CTS_OFF_FLAGS, 8'h00);
    rdc("w0 no effect", `CTS_OFF_FLAGS, 8'h02, 8'h02);
    wr(`CTS_OFF_FLAGS, 8'h02);
    rdc("w1 clears", `CTS_OFF_FLAGS, 8'h02, 8'h00);
    check("irq off", error_irq, 1'b0);
    @(posedge clk);
    overrun_event <= 1'b1;
    @(posedge clk);
    overrun_event <= 1'b0;
    soft_reset_bit <= 1'b1;
    rdc("flags held", `CTS_OFF_FLAGS, 8'hff, 8'h00);
    rdc("enables held", `CTS_OFF_ENABLES, 8'hff, 8'h00);
    @(posedge clk);
    soft_reset_bit <= 1'b0;
  endtask
  // error-count driven flags
  task automatic t_err;
    receive_error_count <= 8'd96;
    cyc(3);
    rdc("rx warn 96", `CTS_OFF_FLAGS, 8'h40, 8'h00);
    @(posedge clk);
    receive_error_count <= 8'd97;
    cyc(3);
    wr(`CTS_OFF_FLAGS, 8'h40);
    rdc("rx warn held", `CTS_OFF_FLAGS, 8'h40, 8'h40);
    @(posedge clk);
    receive_error_count <= 8'd128;
    transmit_error_count <= 9'd200;
    cyc(3);
    rdc("rx passive", `CTS_OFF_FLAGS, 8'h10, 8'h10);
    rdc("tx passive", `CTS_OFF_FLAGS, 8'h08, 8'h08);
    @(posedge clk);
    receive_error_count <= 8'd0;
    transmit_error_count <= 9'd300;
    cyc(3);
    rdc("bus off", `CTS_OFF_FLAGS, 8'h04, 8'h04);
    @(posedge clk);
    transmit_error_count <= 9'd0;
    for (int k = 0; k < 128; k++) begin
      if (k == 127) begin
        wr(`CTS_OFF_FLAGS, 8'h04);
        rdc("bus off held", `CTS_OFF_FLAGS, 8'h04, 8'h04);
      end
      @(posedge clk);
      recessive_run_done <= 1'b1;
      @(posedge clk);
      recessive_run_done <= 1'b0;
    end
    wr(`CTS_OFF_FLAGS, 8'hff);
    rdc("all cleared", `CTS_OFF_FLAGS, 8'hff, 8'h00);
  endtask
  // held swap request: one grant until full is cleared
  task automatic swap_burst(string n);
    int g;
    g = 0;
    @(posedge clk);
    swap_request <= 1'b1;
    repeat (5) begin
      @(posedge clk);
      #1 g += int'(swap_grant === 1'b1);
    end
    @(posedge clk);
    swap_request <= 1'b0;
    check(n, 9'(g), 9'd1);
  endtask
  task automatic t_swap;
    wr(`CTS_OFF_ENABLES, 8'h01);
    swap_burst("one grant");
    rdc("full", `CTS_OFF_FLAGS, 8'h01, 8'h01);
    check("rx irq", receive_irq, 1'b1);
    wr(`CTS_OFF_FLAGS, 8'h01);
    swap_burst("grant again");
  endtask
  // wake-up with and without the filter
  task automatic t_wake;
    for (int f = 0; f < 2; f++) begin
      cfg(f ? 8'h03 : 8'h01, 8'h01, 8'h23);
      wr(`CTS_OFF_ENABLES, 8'h80);
      sleep_mode <= 1'b1;
      cts_bus_node_i.dominant(2);
      cyc(6);
      rdc("short pulse", `CTS_OFF_FLAGS, 8'h80, f ? 8'h00 : 8'h80);
      check("wake irq", wake_irq, f ? 1'b0 : 1'b1);
      cts_bus_node_i.dominant(12);
      cyc(6);
      rdc("long pulse", `CTS_OFF_FLAGS, 8'h80, 8'h80);
      @(posedge clk);
      sleep_mode <= 1'b0;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog well past the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  initial begin
    {reset_n, reg_write, reg_read, soft_reset_bit, sleep_mode} = '0;
    {recessive_run_done, overrun_event, swap_request} = '0;
    {reg_addr, reg_wdata, receive_error_count} = '0;
    transmit_error_count = '0;
    {tx_bit_stream, pll_system_clock, crystal_clock} = 3'h7;
    error_cnt = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_gate;
    t_loop;
    t_time;
    t_triple_sample_enable;
    t_flags;
    t_err;
    t_swap;
    t_wake;
    stop_test;
  end
endmodule
